// ===== src/isf_pkg.sv
// Shared constants for the sample buffer device end and its host end.
// Assumes a 200 MHz core clock on both ends.
package isf_pkg;

	// Clock and link timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCLK_HALF_NS  = 50;
	localparam int SCLK_HALF_CYC =
		(SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Storage geometry
	localparam int          BUF_BYTES   = 1536;
	localparam logic [10:0] BYTES_ONE   = 11'h006;
	localparam logic [10:0] BYTES_TWO   = 11'h00c;
	localparam logic [7:0]  DEPTH_BASE  = 8'h10;
	localparam int          FRAME_BITS  = 16;

	// Device register offsets
	localparam logic [6:0] OFS_CONTROL_ONE = 7'h02;
	localparam logic [6:0] OFS_SENSOR_EN   = 7'h08;
	localparam logic [6:0] OFS_COMMAND     = 7'h0a;
	localparam logic [6:0] OFS_WATERMARK   = 7'h13;
	localparam logic [6:0] OFS_BUF_CONFIG  = 7'h14;
	localparam logic [6:0] OFS_LEVEL_LOW   = 7'h15;
	localparam logic [6:0] OFS_STATUS      = 7'h16;
	localparam logic [6:0] OFS_POP_DATA    = 7'h17;

	// Field positions
	localparam int CTL1_IRQ_SEL_BIT = 2;
	localparam int EN_ACCEL_BIT     = 0;
	localparam int EN_GYRO_BIT      = 1;
	localparam int CFG_SIZE_LSB     = 2;
	localparam int CFG_RD_MODE_BIT  = 7;
	localparam int ST_WTM_BIT       = 7;
	localparam int ST_FULL_BIT      = 6;

	// Command codes
	localparam logic [7:0] CMD_REQ_READOUT = 8'h05;
	localparam logic [7:0] CMD_FLUSH       = 8'h04;

	// Host register map and answers
	localparam logic [7:0] HOST_OFS_CMD    = 8'h00;
	localparam logic [7:0] HOST_OFS_STATUS = 8'h04;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;

	typedef enum logic [1:0] {
		ISF_BYPASS,
		ISF_STOP_FULL,
		ISF_OVERWRITE
	} isf_mode_t;

	// Samples to bytes: six bytes each, twelve with both sensors
	function automatic logic [11:0] isf_to_bytes(input logic [7:0] n,
		input logic both);
		logic [11:0] six;
		six = {2'h0, n, 2'h0} + {3'h0, n, 1'b0};
		return both ? {six[10:0], 1'b0} : six;
	endfunction : isf_to_bytes

	// Pointer advance with wrap at the storage end
	function automatic logic [10:0] isf_wrap(input logic [11:0] p);
		return (p >= 12'(BUF_BYTES)) ? 11'(p - 12'(BUF_BYTES)) : p[10:0];
	endfunction : isf_wrap

endpackage : isf_pkg

// ===== src/isf_link_if.sv
// Serial link between the host end and the sample buffer device end.
// Push-pull pins only; the host makes the serial clock.
`timescale 1ns/1ps
interface isf_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic irq_line_a;
	logic irq_line_b;

	modport device (input sclk, input cs_n, input mosi,
		output miso, output irq_line_a, output irq_line_b);
	modport host (output sclk, output cs_n, output mosi,
		input miso, input irq_line_a, input irq_line_b);
endinterface : isf_link_if

// ===== src/isf_device.sv
// Sample buffer device end: storage, level, flags, irq and serial slave.
// Assumes a host that frames 16-bit mode-0 transfers on the link.
`timescale 1ns/1ps
module isf_device
	import isf_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	isf_link_if.device       link,
	input  wire logic        sample_valid,
	input  wire logic [47:0] accel_data,
	input  wire logic [47:0] gyro_data
);

	logic [7:0]  mem [BUF_BYTES];
	logic [10:0] wr_ptr;
	logic [10:0] rd_ptr;
	logic [10:0] level;
	logic [7:0]  control_one;
	logic [7:0]  sensor_en;
	logic [7:0]  watermark_level;
	logic [7:0]  buffer_config;
	logic        wr_busy;
	logic [3:0]  wr_idx;
	logic [95:0] smp;
	logic        wtm_flag;
	logic        full_flag;
	logic        irq_hold;
	logic        irq_a, irq_b;
	logic [2:0]  s1, s2, s3;
	logic [2:0]  filt;
	logic [4:0]  bit_cnt;
	logic        is_read;
	logic [6:0]  addr;
	logic [6:0]  shin;
	logic [7:0]  tx;
	logic [7:0]  load_byte;
	logic        miso_q;
	logic        pop_armed;
	// Pin filter: a change counts once stages two and three agree
	wire [2:0] next_filt = (s2 & s3) | (filt & (s2 ^ s3));
	wire sclk_rise = next_filt[0] & ~filt[0];
	wire sclk_fall = ~next_filt[0] & filt[0];
	wire cs_idle   = next_filt[1];
	// Configuration decode
	wire both    = sensor_en[EN_ACCEL_BIT] & sensor_en[EN_GYRO_BIT];
	wire any_en  = sensor_en[EN_ACCEL_BIT] | sensor_en[EN_GYRO_BIT];
	wire rd_mode = buffer_config[CFG_RD_MODE_BIT];
	wire [1:0] mode_code = buffer_config[1:0];
	wire [1:0] size_code = buffer_config[CFG_SIZE_LSB +: 2];
	wire [10:0] sbytes = both ? BYTES_TWO : BYTES_ONE;
	wire [7:0] depth_smp = DEPTH_BASE << size_code;
	wire [11:0] depth_b = isf_to_bytes(depth_smp, both);
	wire [11:0] wtm_b = isf_to_bytes(watermark_level, both);
	wire full_now = {1'b0, level} >= depth_b;
	wire wtm_now = (watermark_level != 8'h00)
		&& ({1'b0, level} >= wtm_b);
	// Sample intake
	wire accept = sample_valid && (mode_code != 2'(ISF_BYPASS))
		&& any_en && !rd_mode && !wr_busy;
	wire drop_old = accept && full_now
		&& (mode_code == 2'(ISF_OVERWRITE));
	wire start = accept && (!full_now || drop_old);
	wire [10:0] drop_amt = drop_old ? sbytes : 11'h000;
	wire [95:0] smp_in = both ? {gyro_data, accel_data}
		: sensor_en[EN_ACCEL_BIT] ? {48'h0, accel_data}
		: {48'h0, gyro_data};
	// Serial frame decode
	wire [7:0] byte_val = {shin, next_filt[2]};
	wire byte_done  = sclk_rise && !cs_idle && (&bit_cnt[2:0]);
	wire first_byte = bit_cnt[4:3] == 2'h0;
	wire [6:0] rd_addr = first_byte ? byte_val[6:0] : addr;
	wire do_read = byte_done && (first_byte ? byte_val[7] : is_read);
	wire do_write = byte_done && !is_read && (bit_cnt[4:3] == 2'h1);
	wire can_pop = rd_mode && (level != 11'h000);
	wire arm_pop = do_read && (rd_addr == OFS_POP_DATA) && can_pop;
	// Byte leaves the shifter only now; pop then, not at load
	wire shift_load = sclk_fall && !cs_idle
		&& (bit_cnt[2:0] == 3'h0) && (bit_cnt != 5'h00);
	wire pop = shift_load && pop_armed;
	wire flush = do_write && (addr == OFS_COMMAND)
		&& (byte_val == CMD_FLUSH);
	wire readout_req = do_write && (addr == OFS_COMMAND)
		&& (byte_val == CMD_REQ_READOUT);
	wire [9:0] level_words = level[10:1];
	wire [7:0] status_byte = {wtm_flag, full_flag, 4'h0,
		level_words[9:8]};
	wire [7:0] pop_byte = can_pop ? mem[rd_ptr] : 8'h00;
	wire [7:0] reg_rd =
		(rd_addr == OFS_CONTROL_ONE) ? control_one :
		(rd_addr == OFS_SENSOR_EN)   ? sensor_en :
		(rd_addr == OFS_WATERMARK)   ? watermark_level :
		(rd_addr == OFS_BUF_CONFIG)  ? buffer_config :
		(rd_addr == OFS_LEVEL_LOW)   ? level_words[7:0] :
		(rd_addr == OFS_STATUS)      ? status_byte :
		(rd_addr == OFS_POP_DATA)    ? pop_byte : 8'h00;
	// Next pointer and level values
	wire [10:0] next_level = flush ? 11'h000
		: level + 11'(wr_busy) - 11'(pop) - drop_amt;
	wire [10:0] next_rd_ptr = flush ? 11'h000
		: drop_old ? isf_wrap({1'b0, rd_ptr} + {1'b0, sbytes})
		: pop ? isf_wrap({1'b0, rd_ptr} + 12'h001) : rd_ptr;
	wire [10:0] next_wr_ptr = flush ? 11'h000
		: wr_busy ? isf_wrap({1'b0, wr_ptr} + 12'h001) : wr_ptr;
	// Link pin synchronisers
	always_ff @(posedge core_clk)
	begin
		s1 <= {link.mosi, link.cs_n, link.sclk};
		s2 <= s1;
		s3 <= s2;
	end
	// Storage write, one byte per cycle
	always_ff @(posedge core_clk)
	begin
		if (wr_busy)
			mem[wr_ptr] <= smp[{wr_idx, 3'h0} +: 8];
	end

	// Pointers, level and flags
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			wr_ptr    <= 11'h000;
			rd_ptr    <= 11'h000;
			level     <= 11'h000;
			wtm_flag  <= 1'b0;
			full_flag <= 1'b0;
		end
		else
		begin
			wr_ptr    <= next_wr_ptr;
			rd_ptr    <= next_rd_ptr;
			level     <= next_level;
			wtm_flag  <= wtm_now;
			full_flag <= full_now;
		end
	end

	// Sample writer sequencing
	always_ff @(posedge core_clk)
	begin
		if (reset || flush)
		begin
			wr_busy <= 1'b0;
			wr_idx  <= 4'h0;
			smp     <= 96'h0;
		end
		else if (start)
		begin
			wr_busy <= 1'b1;
			wr_idx  <= 4'h0;
			smp     <= smp_in;
		end
		else if (wr_busy)
		begin
			wr_idx  <= wr_idx + 4'h1;
			wr_busy <= {7'h0, wr_idx} != (sbytes - 11'h001);
		end
	end

	// User registers written over the link
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			control_one     <= 8'h00;
			sensor_en       <= 8'h00;
			watermark_level <= 8'h00;
			buffer_config   <= 8'h00;
		end
		else if (readout_req)
			buffer_config[CFG_RD_MODE_BIT] <= 1'b1;
		else if (do_write)
		begin
			if (addr == OFS_CONTROL_ONE)
				control_one <= byte_val;
			if (addr == OFS_SENSOR_EN)
				sensor_en <= byte_val;
			if (addr == OFS_WATERMARK)
				watermark_level <= byte_val;
			if (addr == OFS_BUF_CONFIG)
				buffer_config <= {byte_val[7] & rd_mode,
					byte_val[6:0]};
		end
	end

	// Watermark irq hold and pin routing
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			irq_hold <= 1'b0;
			irq_a    <= 1'b0;
			irq_b    <= 1'b0;
		end
		else
		begin
			irq_hold <= wtm_now || (irq_hold && rd_mode);
			irq_a    <= irq_hold && control_one[CTL1_IRQ_SEL_BIT];
			irq_b    <= irq_hold && !control_one[CTL1_IRQ_SEL_BIT];
		end
	end

	// Serial slave: shift in on rise, present data on fall
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			filt      <= 3'h2;
			bit_cnt   <= 5'h00;
			is_read   <= 1'b0;
			addr      <= 7'h00;
			shin      <= 7'h00;
			tx        <= 8'h00;
			load_byte <= 8'h00;
			miso_q    <= 1'b0;
			pop_armed <= 1'b0;
		end
		else
		begin
			filt <= next_filt;
			if (cs_idle)
				bit_cnt <= 5'h00;
			else if (sclk_rise)
			begin
				shin    <= byte_val[6:0];
				bit_cnt <= (bit_cnt[4] && (&bit_cnt[2:0])) ? 5'h10
					: bit_cnt + 5'h01;
			end
			if (byte_done && first_byte)
			begin
				is_read <= byte_val[7];
				addr    <= byte_val[6:0];
			end
			if (byte_done)
				load_byte <= do_read ? reg_rd : 8'h00;
			pop_armed <= !cs_idle && (byte_done ? arm_pop : pop_armed);
			if (shift_load)
				{miso_q, tx} <= {load_byte, 1'b0};
			else if (sclk_fall && !cs_idle)
				{miso_q, tx} <= {tx, 1'b0};
		end
	end

	assign link.miso       = miso_q;
	assign link.irq_line_a = irq_a;
	assign link.irq_line_b = irq_b;

endmodule : isf_device

// ===== src/isf_host.sv
// Host end: AXI4-Lite slave registers driving a 16-bit serial master.
// Assumes the device end samples the link on its own 200 MHz clock.
`timescale 1ns/1ps
module isf_host
	import isf_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        reset,
	isf_link_if.host         link,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_GAP} isf_hstate_t;

	isf_hstate_t state;
	logic [7:0]  div;
	logic [3:0]  bit_idx;
	logic [15:0] frame;
	logic [15:0] rx;
	logic        sclk_q;
	logic        cs_n_q;
	logic        mosi_q;
	logic        aw_got;
	logic        w_got;
	logic [7:0]  waddr;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic [2:0]  s1;
	logic [2:0]  s2;
	logic [2:0]  s3;
	logic [2:0]  filt;

	// Pin filter for miso and the two irq lines
	wire [2:0] next_filt = (s2 & s3) | (filt & (s2 ^ s3));
	wire tick     = div == 8'(SCLK_HALF_CYC - 1);
	wire busy     = state != HS_IDLE;
	wire do_write = aw_got && w_got && !s_axi_bvalid;
	wire cmd_hit  = (waddr == HOST_OFS_CMD) && (|wstrb_q[1:0]);
	wire start    = do_write && cmd_hit && !busy;
	wire mapped_w = (waddr == HOST_OFS_CMD) || (waddr == HOST_OFS_STATUS);
	wire [1:0] wresp = (mapped_w && !(cmd_hit && busy)) ? RESP_OKAY
		: RESP_SLVERR;
	wire ar_hs = s_axi_arvalid && s_axi_arready;
	wire [31:0] status_word = {16'h0, rx[7:0], 5'h0, filt[2:1], busy};
	wire [31:0] rd_word =
		(s_axi_araddr == HOST_OFS_CMD) ? {16'h0, frame} : status_word;
	wire mapped_r = (s_axi_araddr == HOST_OFS_CMD)
		|| (s_axi_araddr == HOST_OFS_STATUS);

	// Link input synchronisers
	always_ff @(posedge core_clk)
	begin
		s1 <= {link.irq_line_b, link.irq_line_a, link.miso};
		s2 <= s1;
		s3 <= s2;
	end

	// Write channels, taken in either order
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			waddr         <= 8'h00;
			wdata_q       <= 32'h0;
			wstrb_q       <= 4'h0;
		end
		else
		begin
			s_axi_awready <= !aw_got && !s_axi_bvalid
				&& !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_got && !s_axi_bvalid
				&& !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got <= 1'b1;
				waddr  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got   <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wresp;
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Read channels
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (ar_hs)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= mapped_r ? rd_word : 32'h0;
			s_axi_rresp   <= mapped_r ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
		else
			s_axi_arready <= !s_axi_rvalid;
	end

	// Serial master: mode 0, msb first, clock from a divider
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state   <= HS_IDLE;
			div     <= 8'h00;
			bit_idx <= 4'h0;
			frame   <= 16'h0;
			rx      <= 16'h0;
			sclk_q  <= 1'b0;
			cs_n_q  <= 1'b1;
			mosi_q  <= 1'b0;
			filt    <= 3'h0;
		end
		else
		begin
			filt <= next_filt;
			div  <= (tick || !busy) ? 8'h00 : div + 8'h01;
			unique case (state)
				HS_IDLE:
					if (start)
					begin
						frame   <= wdata_q[15:0];
						mosi_q  <= wdata_q[FRAME_BITS - 1];
						cs_n_q  <= 1'b0;
						bit_idx <= 4'h0;
						state   <= HS_SHIFT;
					end
				HS_SHIFT:
					if (tick && !sclk_q)
					begin
						sclk_q <= 1'b1;
						rx     <= {rx[14:0], next_filt[0]};
					end
					else if (tick)
					begin
						sclk_q  <= 1'b0;
						bit_idx <= bit_idx + 4'h1;
						mosi_q  <= frame[4'hf - bit_idx - 4'h1];
						if (&bit_idx)
						begin
							cs_n_q <= 1'b1;
							state  <= HS_GAP;
						end
					end
				HS_GAP:
					if (tick)
						state <= HS_IDLE;
			endcase
		end
	end

	assign link.sclk = sclk_q;
	assign link.cs_n = cs_n_q;
	assign link.mosi = mosi_q;

endmodule : isf_host

// ===== tb/isf_link_props.sv
// Link checker: timing and levels of the serial link pins.
// Assumes the host end makes sclk from the 200 MHz core clock.
`timescale 1ns/1ps
module isf_link_props
	import isf_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic irq_line_a,
	input wire logic irq_line_b
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// Pins quiet straight after reset
	sequence s_quiet;
		cs_n && !sclk && !mosi && !miso && !irq_line_a && !irq_line_b;
	endsequence
	// Frame opens with the clock low
	sequence s_open;
		$fell(cs_n) ##0 !sclk;
	endsequence

	property p_quiet;
		$fell(reset) |-> s_quiet;
	endproperty
	property p_idle_clk;
		cs_n |-> !sclk;
	endproperty
	property p_frame_len;
		s_open |-> !cs_n [*8];
	endproperty
	property p_gap;
		$rose(cs_n) |-> cs_n [*8];
	endproperty
	property p_high_half;
		$rose(sclk) |-> sclk [*8];
	endproperty
	property p_low_half;
		$fell(sclk) && !cs_n |-> !sclk [*8];
	endproperty
	property p_mosi_hold;
		sclk && $past(sclk) |-> $stable(mosi);
	endproperty
	property p_one_pin;
		!(irq_line_a && irq_line_b);
	endproperty

	a_quiet:
		assert property (p_quiet) else $error("link not quiet after reset");
	a_idle_clk:
		assert property (p_idle_clk) else $error("sclk moves outside frame");
	a_frame_len:
		assert property (p_frame_len) else $error("frame too short");
	a_gap:
		assert property (p_gap) else $error("gap between frames too short");
	a_high_half:
		assert property (p_high_half) else $error("sclk high phase short");
	a_low_half:
		assert property (p_low_half) else $error("sclk low phase short");
	a_mosi_hold:
		assert property (p_mosi_hold) else $error("mosi moved while sclk high");
	a_one_pin:
		assert property (p_one_pin) else $error("both irq pins high");
endmodule : isf_link_props

// ===== tb/imu_sample_fifo_bench.sv
// Bench: host end and device end joined by the link interface.
// Assumes register access through the host end's AXI4-Lite port.
`timescale 1ns/1ps
module imu_sample_fifo_bench;
	import isf_pkg::*;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic        sample_valid = 1'b0;
	logic [47:0] accel_data = '0;
	logic [47:0] gyro_data = '0;
	logic [7:0]  s_axi_awaddr = '0;
	logic [7:0]  s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0]  s_axi_wstrb = '0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int          fail_count = 0;
	int          checked = 0;
	logic [7:0]  b;
	logic [31:0] w;
	logic [1:0]  bresp_seen;

	isf_link_if link ();
	isf_device u_isf_device (.core_clk(core_clk), .reset(reset),
		.link(link.device), .sample_valid(sample_valid),
		.accel_data(accel_data), .gyro_data(gyro_data));
	isf_host u_isf_host (.core_clk(core_clk), .reset(reset),
		.link(link.host), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	isf_link_props u_props (.core_clk(core_clk), .reset(reset),
		.sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
		.miso(link.miso), .irq_line_a(link.irq_line_a),
		.irq_line_b(link.irq_line_b));

	// Clock
	initial
	begin
		forever #(CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// AXI write: both items offered, each released when taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		bresp_seen = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_read

	task automatic wait_idle(output logic [31:0] d);
		logic [1:0] r;
		d = 32'h1;
		for (int n = 0; n < 200 && d[0] !== 1'b0; n++)
			axi_read(HOST_OFS_STATUS, d, r);
		check({7'h0, d[0]}, 8'h00);
	endtask : wait_idle

	task automatic dev_wr(input logic [6:0] a, input logic [7:0] v);
		logic [31:0] d;
		axi_write(HOST_OFS_CMD, {16'h0, 1'b0, a, v});
		wait_idle(d);
	endtask : dev_wr

	task automatic dev_rd(input logic [6:0] a, output logic [7:0] v);
		logic [31:0] d;
		axi_write(HOST_OFS_CMD, {16'h0, 1'b1, a, 8'h00});
		wait_idle(d);
		v = d[15:8];
	endtask : dev_rd

	task automatic chk_irq(input logic [1:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axi_read(HOST_OFS_STATUS, d, r);
		check({6'h0, d[2:1]}, {6'h0, e});
	endtask : chk_irq

	function automatic logic [7:0] exp_byte(input logic [7:0] i, input int k);
		return k[0] ? 8'(8'h10 * (k / 2 + 1)) : i;
	endfunction : exp_byte

	task automatic push(input logic [7:0] i);
		@(posedge core_clk);
		sample_valid <= 1'b1;
		accel_data <= {8'h30, i, 8'h20, i, 8'h10, i};
		gyro_data <= {8'h60, i, 8'h50, i, 8'h40, i};
		@(posedge core_clk);
		sample_valid <= 1'b0;
		repeat (20) @(posedge core_clk);
	endtask : push

	task automatic t_reset_regs();
		logic [31:0] d;
		logic [1:0]  r;
		dev_rd(OFS_LEVEL_LOW, b);
		check(b, 8'h00);
		dev_rd(OFS_STATUS, b);
		check(b, 8'h00);
		dev_rd(7'h30, b);
		check(b, 8'h00);
		axi_read(8'h08, d, r);
		check({6'h0, r}, {6'h0, RESP_SLVERR});
		// Second command while the first frame runs is refused
		axi_write(HOST_OFS_CMD, {16'h0, 1'b1, OFS_STATUS, 8'h00});
		check({6'h0, bresp_seen}, {6'h0, RESP_OKAY});
		axi_write(HOST_OFS_CMD, {16'h0, 1'b0, OFS_WATERMARK, 8'h07});
		check({6'h0, bresp_seen}, {6'h0, RESP_SLVERR});
		wait_idle(d);
		dev_rd(OFS_WATERMARK, b);
		check(b, 8'h00);
	endtask : t_reset_regs

	// Every depth code filled past full in stop mode
	task automatic t_depths();
		dev_wr(OFS_SENSOR_EN, 8'h01);
		push(8'h00);
		dev_rd(OFS_LEVEL_LOW, b);
		check(b, 8'h00);
		dev_wr(OFS_WATERMARK, 8'h04);
		dev_wr(OFS_CONTROL_ONE, 8'h04);
		for (int k = 3; k >= 0; k--)
		begin
			dev_wr(OFS_COMMAND, CMD_FLUSH);
			dev_rd(OFS_LEVEL_LOW, b);
			check(b, 8'h00);
			dev_wr(OFS_BUF_CONFIG, 8'((k << 2) | 1));
			for (int i = 0; i < (16 << k) + 2; i++)
				push(8'(i));
			w = (16 << k) * 3;
			dev_rd(OFS_LEVEL_LOW, b);
			check(b, w[7:0]);
			dev_rd(OFS_STATUS, b);
			check(b, {2'b11, 4'h0, w[9:8]});
			chk_irq(2'b01);
		end
	endtask : t_depths

	task automatic t_readout();
		dev_wr(OFS_COMMAND, CMD_REQ_READOUT);
		dev_rd(OFS_BUF_CONFIG, b);
		check(b, 8'h81);
		for (int k = 0; k < 6; k++)
		begin
			dev_rd(OFS_POP_DATA, b);
			check(b, exp_byte(8'h00, k));
		end
		push(8'h55);
		dev_rd(OFS_LEVEL_LOW, b);
		check(b, 8'd45);
		dev_wr(OFS_COMMAND, CMD_FLUSH);
		dev_rd(OFS_STATUS, b);
		check(b, 8'h00);
		chk_irq(2'b01);
		dev_wr(OFS_BUF_CONFIG, 8'h01);
		chk_irq(2'b00);
		push(8'h09);
		dev_rd(OFS_LEVEL_LOW, b);
		check(b, 8'd3);
	endtask : t_readout

	task automatic t_overwrite();
		dev_wr(OFS_COMMAND, CMD_FLUSH);
		dev_wr(OFS_BUF_CONFIG, 8'h02);
		for (int i = 0; i < 17; i++)
			push(8'(i));
		dev_rd(OFS_LEVEL_LOW, b);
		check(b, 8'd48);
		dev_wr(OFS_COMMAND, CMD_REQ_READOUT);
		dev_rd(OFS_POP_DATA, b);
		check(b, 8'h01);
		dev_wr(OFS_BUF_CONFIG, 8'h02);
	endtask : t_overwrite

	task automatic t_both();
		dev_wr(OFS_SENSOR_EN, 8'h03);
		dev_wr(OFS_CONTROL_ONE, 8'h00);
		dev_wr(OFS_WATERMARK, 8'h01);
		dev_wr(OFS_COMMAND, CMD_FLUSH);
		push(8'h07);
		dev_rd(OFS_LEVEL_LOW, b);
		check(b, 8'd6);
		chk_irq(2'b10);
		dev_wr(OFS_COMMAND, CMD_REQ_READOUT);
		for (int k = 0; k < 12; k++)
		begin
			dev_rd(OFS_POP_DATA, b);
			check(b, exp_byte(8'h07, k));
		end
	endtask : t_both

	// Main sequence
	initial
	begin
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		t_reset_regs();
		t_depths();
		t_readout();
		t_overwrite();
		t_both();
		tally_and_finish();
	end

	// Watchdog
	initial
	begin
		repeat (100000) @(posedge core_clk);
		fail_count++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule : imu_sample_fifo_bench
